/* File: include/strap_pkg.sv */
// Purpose: Shared constants for the reset strap and status pin block
// Assumes: One 100 MHz clock, asynchronous active-high reset
// Notes:   Strap encodings and pin counts live here only
package strap_pkg;

    localparam int  NUM_PORTS        = 4;
    localparam int  SYNC_STAGES      = 3;
    // Interface-select strap encoding
    localparam logic IFACE_EEPROM_MASTER = 1'h1;
    localparam logic IFACE_SMBUS_TARGET  = 1'h0;
    // Power-management strap encoding, active low
    localparam logic PWRMGMT_ENABLED     = 1'h0;
    // Polarity strap encoding
    localparam logic POLARITY_ACTIVE_HIGH = 1'h1;
    // Settle cycles after reset release before sampling straps
    localparam int  STRAP_SETTLE_CYCLES = 5;
    localparam logic [2:0] SETTLE_INIT  = 3'h0;
    localparam logic [2:0] SETTLE_DONE  = 3'(STRAP_SETTLE_CYCLES - 1);

endpackage : strap_pkg

/* File: logic/strap_sync.sv */
// Purpose: Three-stage synchroniser for pin inputs
// Assumes: Input may change asynchronously to core_clk_i
// Notes:   A change counts once stages two and three agree
module strap_sync
    import strap_pkg::*;
#(
    parameter int WIDTH = 3
)
(
    // Clock and reset
    input  wire logic             core_clk_i,
    input  wire logic             reset_i,
    // Pin side
    input  wire logic [WIDTH-1:0] pin_i,
    // Filtered level
    output logic      [WIDTH-1:0] level_o
);

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;
    wire  [WIDTH-1:0] agree = ~(stage2 ^ stage3);

    // First stage is read by stage2 only
    always_ff @(posedge core_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            stage1  <= '0;
            stage2  <= '0;
            stage3  <= '0;
            level_o <= '0;
        end
        else
        begin
            stage1  <= pin_i;
            stage2  <= stage1;
            stage3  <= stage2;
            level_o <= (agree & stage3) | (~agree & level_o);
        end
    end

endmodule : strap_sync

/* File: logic/reset_strap_status_pins.sv */
// Purpose: Strap latch and status drive for three dual-function pins
// Assumes: Pins pulled by board resistors; pins idle as inputs in reset
// Notes:   Straps taken once, a few cycles after reset release
//          The synchroniser is cleared by reset, so the strap sample waits
//          until its filtered level has caught up with the pin.
//          Status drive starts only after capture, so the board resistor
//          is never fought while the strap is still being read.
//          Port power pins stay low until capture, whatever the polarity:
//          an active-low board sees its ports on for those few cycles.
//
// Function
// [R1] Latch interface-select strap at reset release: 1 EEPROM master, 0 SMBus target.
// [R2] With status output on, drive interface-select pin with upstream SuperSpeed suspend.
// [R3] Latch power-management strap: 0 enables power switching and overcurrent, 1 disables.
// [R4] In SMBus target mode, address bit 1 comes from power-management strap level.
// [R5] With status output on, drive power-management pin with upstream SuperSpeed connection.
// [R6] Full power management drives four per-port power and charge enables.
// [R7] Latch polarity strap: 0 power outputs active low, 1 active high.
// [R8] Board must enable power switching whenever battery charging is used.
// [R9] Strap 1 makes two-wire pins EEPROM master; 0 makes them SMBus target.
// [R10] Pins stay inputs during reset; latched straps hold until next reset.
module reset_strap_status_pins
    import strap_pkg::*;
#(
    parameter int PORTS = NUM_PORTS
)
(
    // Clock and reset
    input  wire logic             core_clk_i,
    input  wire logic             reset_i,
    // Dual-function pins
    input  wire logic             iface_select_strap_i,
    output logic                  iface_select_strap_o,
    output logic                  iface_select_strap_oe_o,
    input  wire logic             power_management_strap_i,
    output logic                  power_management_strap_o,
    output logic                  power_management_strap_oe_o,
    input  wire logic             power_output_polarity_strap_i,
    // Hub core status and control
    input  wire logic             status_output_enable_i,
    input  wire logic             ss_suspended_i,
    input  wire logic             ss_connected_i,
    input  wire logic [PORTS-1:0] port_power_request_i,
    input  wire logic [PORTS-1:0] port_charge_request_i,
    // Latched configuration
    output logic                  straps_valid_o,
    output logic                  eeprom_master_mode_o,
    output logic                  smbus_target_mode_o,
    output logic                  power_switching_enabled_o,
    output logic                  target_address_bit1_o,
    output logic                  power_active_high_o,
    // Port power pins
    output logic [PORTS-1:0]      port_power_enable_o,
    output logic [PORTS-1:0]      port_charge_enable_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisation

    logic [2:0] pin_level;

    // Pin bundle: bit 0 interface select, bit 1 power management, bit 2 polarity
    wire  [2:0] pin_raw = {power_output_polarity_strap_i, power_management_strap_i, iface_select_strap_i};

    strap_sync #(
        .WIDTH (3)
    ) u_sync (
        .core_clk_i (core_clk_i),
        .reset_i    (reset_i),
        .pin_i      (pin_raw),
        .level_o    (pin_level)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Strap capture after release

    // Release timeline, edges counted from the first edge after release:
    //   edge 1  first stage takes the pin
    //   edge 2  second stage takes the pin
    //   edge 3  third stage takes the pin
    //   edge 4  second and third agree, filtered level shows the pin
    //   edge 5  strap registers take the filtered level, capture flag set
    //   edge 6  configuration outputs and straps_valid_o rise
    // Sampling earlier would latch the cleared synchroniser, not the pin.
    // The settle count is frozen after capture, so nothing moves until the
    // next reset and later pin activity (status drive) is ignored.
    // Straps must hold from release up to edge 5; board resistors do that.
    // The capture edge is fixed by a count rather than by watching the
    // pin, because a floating strap would otherwise never settle.

    logic [2:0] settle;
    logic       captured;
    logic       iface_strap;
    logic       pwrmgmt_strap;
    logic       polarity_strap;
    wire        take_strap = !captured && (settle == SETTLE_DONE);

    // Settle count, frozen once the straps are taken
    always_ff @(posedge core_clk_i or posedge reset_i)
    begin
        if (reset_i)
            settle <= SETTLE_INIT;
        else if (!captured && settle != SETTLE_DONE)
            settle <= settle + 3'h1;
    end

    // Capture flag; only reset clears it
    always_ff @(posedge core_clk_i or posedge reset_i)
    begin
        if (reset_i)
            captured <= 1'b0;
        else if (take_strap)
            captured <= 1'b1;                  // [R10]
    end

    // One capture only; held until the next reset
    always_ff @(posedge core_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            iface_strap    <= IFACE_EEPROM_MASTER;
            pwrmgmt_strap  <= ~PWRMGMT_ENABLED;
            polarity_strap <= POLARITY_ACTIVE_HIGH;
        end
        else if (take_strap)
        begin
            iface_strap    <= pin_level[0];    // [R1]
            pwrmgmt_strap  <= pin_level[1];    // [R3]
            polarity_strap <= pin_level[2];    // [R7]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Decoded configuration

    // Strap decodes, meaningful only once captured is high
    wire smbus_mode  = (iface_strap == IFACE_SMBUS_TARGET);              // [R9]
    wire pwr_enabled = (pwrmgmt_strap == PWRMGMT_ENABLED);               // [R3]
    wire act_high    = (polarity_strap == POLARITY_ACTIVE_HIGH);         // [R7]
    wire addr_bit1   = smbus_mode & pwrmgmt_strap;                       // [R4]
    // Status drive waits for capture so a strap is never overdriven
    wire drive_stat  = captured & status_output_enable_i;                // [R10]

    // Requests pass only with switching on; polarity flips the power pin level, not the charge pins
    wire [PORTS-1:0] next_power  = (pwr_enabled ? port_power_request_i : '0)
                                   ^ {PORTS{~act_high}};                 // [R6]
    wire [PORTS-1:0] next_charge = pwr_enabled ? port_charge_request_i : '0; // [R6]

    ////////////////////////////////////////////////////////////////////////////
    // Registered outputs

    // Interface-select pin: released in reset, suspend status afterwards
    always_ff @(posedge core_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            iface_select_strap_o    <= 1'b0;
            iface_select_strap_oe_o <= 1'b0;                      // [R10]
        end
        else
        begin
            iface_select_strap_o    <= drive_stat & ss_suspended_i;  // [R2]
            iface_select_strap_oe_o <= drive_stat;                   // [R2]
        end
    end

    // Power-management pin: released in reset, connection status afterwards
    always_ff @(posedge core_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            power_management_strap_o    <= 1'b0;
            power_management_strap_oe_o <= 1'b0;                  // [R10]
        end
        else
        begin
            power_management_strap_o    <= drive_stat & ss_connected_i;  // [R5]
            power_management_strap_oe_o <= drive_stat;                   // [R5]
        end
    end

    // Configuration flags, all zero until capture
    always_ff @(posedge core_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            straps_valid_o            <= 1'b0;
            eeprom_master_mode_o      <= 1'b0;
            smbus_target_mode_o       <= 1'b0;
            power_switching_enabled_o <= 1'b0;
            target_address_bit1_o     <= 1'b0;
            power_active_high_o       <= 1'b0;
        end
        else
        begin
            straps_valid_o            <= captured;
            eeprom_master_mode_o      <= captured & ~smbus_mode;  // [R9]
            smbus_target_mode_o       <= captured & smbus_mode;   // [R9]
            power_switching_enabled_o <= captured & pwr_enabled;
            target_address_bit1_o     <= captured & addr_bit1;    // [R4]
            power_active_high_o       <= captured & act_high;
        end
    end

    // Port power pins; low before capture even on an active-low board
    always_ff @(posedge core_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            port_power_enable_o  <= '0;
            port_charge_enable_o <= '0;
        end
        else
        begin
            port_power_enable_o  <= captured ? next_power : '0;   // [R6]
            port_charge_enable_o <= captured ? next_charge : '0;  // [R6]
        end
    end

endmodule : reset_strap_status_pins

/* File: verif/strap_chk.sv */
// Purpose: Port checks for the strap and status pin block
// Assumes: One clock, asynchronous active-high reset
// Notes:   Config outputs are held to pins sampled at capture
module strap_chk
    import strap_pkg::*;
#(
    parameter int PORTS = NUM_PORTS
)
(
    // Clock, reset and single-bit ports
    input wire logic             core_clk_i, reset_i, iface_select_strap_i, power_management_strap_i,
    input wire logic             power_output_polarity_strap_i, status_output_enable_i, ss_suspended_i,
    input wire logic             ss_connected_i, iface_select_strap_o, iface_select_strap_oe_o,
    input wire logic             power_management_strap_o, power_management_strap_oe_o, straps_valid_o,
    input wire logic             eeprom_master_mode_o, smbus_target_mode_o, power_switching_enabled_o,
    input wire logic             target_address_bit1_o, power_active_high_o,
    // Port power vectors
    input wire logic [PORTS-1:0] port_power_request_i, port_charge_request_i,
    input wire logic [PORTS-1:0] port_power_enable_o, port_charge_enable_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (reset_i);
    // Inversion mask, all ones when power outputs are active low
    wire [PORTS-1:0] inv = {PORTS{~power_active_high_o}};
    sequence s_cap;
        !straps_valid_o ##1 straps_valid_o;
    endsequence
    ////////////////////////////////////////////////////////////////////////////////
    cap_values_a: assert property (s_cap |-> power_active_high_o == $past(power_output_polarity_strap_i)
        && power_switching_enabled_o == !$past(power_management_strap_i)
        && eeprom_master_mode_o == $past(iface_select_strap_i)) else $error("strap capture wrong");
    mode_excl_a: assert property (straps_valid_o |-> eeprom_master_mode_o ^ smbus_target_mode_o)
        else $error("both or no bus modes");
    addr_bit_a: assert property (straps_valid_o |-> target_address_bit1_o ==
        (smbus_target_mode_o & !power_switching_enabled_o)) else $error("address bit wrong");
    hold_cfg_a: assert property (straps_valid_o ##1 1 |-> $stable({eeprom_master_mode_o,
        power_switching_enabled_o, power_active_high_o, target_address_bit1_o, straps_valid_o}))
        else $error("latched config moved");
    idle_pins_a: assert property (!straps_valid_o |-> !iface_select_strap_oe_o && !power_management_strap_oe_o)
        else $error("pin driven before capture");
    drive_en_a: assert property ($past(straps_valid_o) |-> iface_select_strap_oe_o ==
        $past(status_output_enable_i) && power_management_strap_oe_o == iface_select_strap_oe_o)
        else $error("drive enable wrong");
    suspend_a: assert property (iface_select_strap_oe_o |-> iface_select_strap_o == $past(ss_suspended_i))
        else $error("suspend status wrong");
    connect_a: assert property (power_management_strap_oe_o |-> power_management_strap_o == $past(ss_connected_i))
        else $error("connect status wrong");
    power_en_a: assert property ($past(straps_valid_o) |-> port_power_enable_o ==
        (($past(port_power_request_i) & {PORTS{power_switching_enabled_o}}) ^ inv)) else $error("power enable wrong");
    charge_en_a: assert property ($past(straps_valid_o) |-> port_charge_enable_o ==
        ($past(port_charge_request_i) & {PORTS{power_switching_enabled_o}})) else $error("charge enable wrong");
endmodule : strap_chk

/* File: verif/board_model.sv */
// Purpose: Board strap resistors on the three dual-function pins
// Assumes: Hub drive overrides the resistor while enabled
// Notes:   Polarity pin is never driven by the hub
module board_model
(
    // Strap resistor levels
    input  wire logic [2:0] strap_i,
    // Hub pin drive
    input  wire logic       iface_o_i, iface_oe_i, pm_o_i, pm_oe_i,
    // Levels seen on the pins
    output wire logic [2:0] pin_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Resistor wins only while the hub releases the pin
    assign pin_o[0] = iface_oe_i ? iface_o_i : strap_i[0];
    assign pin_o[1] = pm_oe_i ? pm_o_i : strap_i[1];
    assign pin_o[2] = strap_i[2];
endmodule : board_model

/* File: verif/testbench.sv */
// Purpose: Strap capture and status drive tests
// Assumes: Straps stable around reset release
// Notes:   All eight strap combinations, one reset each
module testbench;
    import strap_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic       core_clk_i = 0, reset_i = 1, en = 0, su = 0, cn = 0;
    logic [2:0] strap = 0;
    logic [3:0] pr = 0, cr = 0;
    wire  logic [2:0] pin;
    wire  logic io, ioe, po, poe, sv, em, st, se, ab, ah;
    wire  logic [3:0] pe, ce;
    int         miscompares = 0, tests_run = 0, cycles = 0;
    always #5 core_clk_i = ~core_clk_i;
    // Hang guard, tests need about 180 cycles
    always @(posedge core_clk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 2000)
        begin
            miscompares++;
            finish_test();
        end
    end
    reset_strap_status_pins dut_u (.core_clk_i(core_clk_i), .reset_i(reset_i), .iface_select_strap_i(pin[0]),
        .iface_select_strap_o(io), .iface_select_strap_oe_o(ioe), .power_management_strap_i(pin[1]),
        .power_management_strap_o(po), .power_management_strap_oe_o(poe), .power_output_polarity_strap_i(pin[2]),
        .status_output_enable_i(en), .ss_suspended_i(su), .ss_connected_i(cn), .port_power_request_i(pr),
        .port_charge_request_i(cr), .straps_valid_o(sv), .eeprom_master_mode_o(em), .smbus_target_mode_o(st),
        .power_switching_enabled_o(se), .target_address_bit1_o(ab), .power_active_high_o(ah),
        .port_power_enable_o(pe), .port_charge_enable_o(ce));
    board_model board_u (.strap_i(strap), .iface_o_i(io), .iface_oe_i(ioe), .pm_o_i(po), .pm_oe_i(poe), .pin_o(pin));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [3:0] exp, got);
        tests_run++;
        if (exp !== got)
        begin
            miscompares++;
            $display("[FAIL] %s exp %h got %h", name, exp, got);
        end
    endtask : chk
    // Reset with given straps, then wait for capture
    task automatic start(input logic [2:0] s);
        @(posedge core_clk_i);
        reset_i <= 1'h1;
        strap <= s;
        repeat (8) @(posedge core_clk_i);
        reset_i <= 1'h0;
        for (int i = 0; i < 20 && sv !== 1'h1; i++) @(posedge core_clk_i);
        #1;
    endtask : start
    // Apply status and requests, sample one edge later
    task automatic put(input logic e, s, c, input logic [3:0] p, q);
        @(posedge core_clk_i);
        {en, su, cn, pr, cr} <= {e, s, c, p, q};
        @(posedge core_clk_i);
        #1;
    endtask : put
    task automatic finish_test;
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : finish_test
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        for (int c = 0; c < 8; c++)
        begin
            logic [2:0] k;
            k = 3'(c);
            start(k);
            chk("valid", 4'h1, {3'h0, sv});
            chk("mode", {2'h0, k[0], ~k[0]}, {2'h0, em, st});
            chk("switch", {3'h0, ~k[1]}, {3'h0, se});
            chk("addr", {3'h0, ~k[0] & k[1]}, {3'h0, ab});
            chk("polarity", {3'h0, k[2]}, {3'h0, ah});
            strap <= ~k;
            put(1'h0, 1'h1, 1'h1, 4'h5, 4'h3);
            chk("idle oe", 4'h0, {2'h0, ioe, poe});
            chk("power", (k[1] ? 4'h0 : 4'h5) ^ {4{~k[2]}}, pe);
            chk("charge", k[1] ? 4'h0 : 4'h3, ce);
            put(1'h1, 1'h1, 1'h0, 4'hA, 4'hC);
            chk("drive hi", 4'hE, {ioe, io, poe, po});
            chk("held", {2'h0, k[0], ~k[1]}, {2'h0, em, se});
            chk("power2", (k[1] ? 4'h0 : 4'hA) ^ {4{~k[2]}}, pe);
            put(1'h1, 1'h0, 1'h1, 4'hA, 4'hC);
            chk("drive lo", 4'hB, {ioe, io, poe, po});
            $display("test %0d done", c);
        end
        finish_test();
    end
endmodule : testbench
bind reset_strap_status_pins strap_chk #(.PORTS(PORTS)) chk_u (.*);
